// *** pkg/aph_pkg.sv ***
// Shared constants and types for the converter parallel host port
package aph_pkg;
    localparam int APH_DATA_W = 8;
    localparam int APH_RESULT_W = 12;
    localparam int APH_UPPER_W = 4;
    localparam int APH_CONV_CYCLES = 13;
    localparam int APH_ACQ_CYCLES = 3;
    localparam int APH_ACQMODE_BIT = 5;
    localparam int APH_CNT_W = 4;
    localparam int APH_CLK_DIV = 8;
    localparam logic [11:0] APH_RESULT_RST = 12'h000;
    localparam logic [7:0] APH_CTRL_RST = 8'h00;

    typedef enum logic [1:0]
    {
        APH_IDLE = 2'b00,
        APH_ACQ = 2'b01,
        APH_CONV = 2'b11,
        APH_DONE = 2'b10
    } aph_state_e;

    typedef enum logic [1:0]
    {
        APH_H_IDLE = 2'b00,
        APH_H_WRITE = 2'b01,
        APH_H_READ = 2'b11,
        APH_H_GAP = 2'b10
    } aph_hstate_e;
endpackage

// *** pkg/aph_bus_if.sv ***
// Byte-wide host bus between converter port and microprocessor
interface aph_bus_if;
    logic cs_n;
    logic wr_n;
    logic rd_n;
    logic upper_nibble_select;
    logic conv_clk;
    logic [7:0] host_data;
    logic host_data_oe;
    logic [7:0] dev_data;
    logic dev_data_oe;
    logic done_n;
    logic done_oe;

    modport device
    (
        input cs_n,
        input wr_n,
        input rd_n,
        input upper_nibble_select,
        input conv_clk,
        input host_data,
        output dev_data,
        output dev_data_oe,
        output done_n,
        output done_oe
    );

    modport host
    (
        output cs_n,
        output wr_n,
        output rd_n,
        output upper_nibble_select,
        output conv_clk,
        output host_data,
        output host_data_oe,
        input dev_data,
        input dev_data_oe,
        input done_n,
        input done_oe
    );
endinterface

// *** src/aph_device.sv ***
// Converter end: control capture, acquisition and conversion timing, result read
//
// Overview of operation
// [RULE_01] Completion flag falls low when result ready
// [RULE_02] Read strobe fall under select drives data
// [RULE_03] Internal mode: write rise captures, starts acquisition
// [RULE_04] External mode: second write rise starts conversion
// [RULE_05] Select high releases flag and data bus
// [RULE_06] External clock mode: host supplies running clock
// [RULE_07] Internal clock mode: clock pin held static
// [RULE_08] Upper select picks four MSBs or LSBs
// [RULE_09] Flag returns high on read or write
// [RULE_10] Conversion lasts thirteen clock cycles
// [RULE_11] Write during conversion aborts, restarts acquisition
// [RULE_12] Bus driven only while select and read low
module aph_device
    import aph_pkg::*;
#(
    parameter int CONV_CYCLES = APH_CONV_CYCLES,
    parameter int ACQ_CYCLES = APH_ACQ_CYCLES
)
(
    input wire logic clk,
    input wire logic srst,
    input wire logic use_ext_clock,
    input wire logic [11:0] sample_in,
    output logic [7:0] ctrl_byte,
    output logic sample_strobe,
    output logic converting,
    aph_bus_if.device bus
);
    initial
    begin
        // Both counts share one 4-bit counter, so 15 is the ceiling
        if (CONV_CYCLES < 1 || CONV_CYCLES > 15)
            $error("aph_device: conversion count must be 1 to 15");
        if (ACQ_CYCLES < 1 || ACQ_CYCLES > 15)
            $error("aph_device: acquisition count must be 1 to 15");
    end

    aph_state_e state_q, state_d;
    logic [APH_CNT_W-1:0] cnt_q, cnt_d;
    logic [7:0] ctrl_q, ctrl_d;
    logic [11:0] result_q, result_d;
    logic done_q, done_d;
    // Pin history for edge detection
    logic wr_q, wr_d;
    logic rd_q, rd_d;
    logic ck_q, ck_d;
    logic [7:0] data_q, data_d;
    logic sample_q, sample_d;
    logic wr_rise;
    logic rd_fall;
    logic tick;

    // Strobe edges qualified by chip select; the host must hold select past
    // the write strobe's rise, or the write is ignored
    assign wr_rise = wr_q == 1'b0 && bus.wr_n == 1'b1 && bus.cs_n == 1'b0;
    assign rd_fall = rd_q == 1'b1 && bus.rd_n == 1'b0 && bus.cs_n == 1'b0; // RULE_02
    // Timing ticks: falling edge of pin clock, or every clk internally
    // Internal mode ignores the pin, which the host holds static then
    assign tick = use_ext_clock ? (ck_q && !bus.conv_clk) : 1'b1; // RULE_06

    // Sequencer next state. A write always wins, even in the cycle a conversion
    // would finish: it restarts acquisition, so a stale result is never flagged
    // as new.
    always_comb
    begin
        state_d = state_q;
        cnt_d = cnt_q;
        ctrl_d = ctrl_q;
        result_d = result_q;
        done_d = done_q;
        sample_d = 1'b0;
        if (wr_rise)
        begin
            // Every accepted write replaces the control byte
            ctrl_d = bus.host_data;
            done_d = 1'b0; // RULE_09
            cnt_d = '0;
            if (state_q == APH_ACQ && !bus.host_data[APH_ACQMODE_BIT]
                && ctrl_q[APH_ACQMODE_BIT])
            begin
                // Second write of an external acquisition samples at once
                state_d = APH_CONV; // RULE_04
                sample_d = 1'b1;
            end
            else
                state_d = APH_ACQ; // RULE_03 RULE_11
        end
        else
        begin
            if (rd_fall)
                done_d = 1'b0; // RULE_09
            unique case (state_q)
                // Nothing to time; the result stays readable
                APH_IDLE, APH_DONE:
                    ;
                APH_ACQ:
                begin
                    // External acquisition waits for the second write
                    if (!ctrl_q[APH_ACQMODE_BIT] && tick)
                    begin
                        if (cnt_q == APH_CNT_W'(ACQ_CYCLES - 1))
                        begin
                            state_d = APH_CONV; // RULE_03
                            sample_d = 1'b1;
                            cnt_d = '0;
                        end
                        else
                            cnt_d = cnt_q + 1'b1;
                    end
                end
                APH_CONV:
                begin
                    if (tick)
                    begin
                        if (cnt_q == APH_CNT_W'(CONV_CYCLES - 1))
                        begin
                            // Result taken on the last tick, flag raised with it
                            state_d = APH_DONE;
                            result_d = sample_in;
                            done_d = 1'b1; // RULE_01 RULE_10
                        end
                        else
                            cnt_d = cnt_q + 1'b1; // RULE_10
                    end
                end
            endcase
        end
    end

    // Read data selection, registered on the read strobe fall
    // Keeps following the upper select while the read is held low, since
    // the host may switch halves without releasing the strobe
    always_comb
    begin
        data_d = data_q;
        if (rd_fall || (bus.cs_n == 1'b0 && bus.rd_n == 1'b0))
            data_d = bus.upper_nibble_select
                ? {4'h0, result_q[11:8]} : result_q[7:0]; // RULE_08
    end

    // Pin history next values
    always_comb
    begin
        wr_d = bus.wr_n;
        rd_d = bus.rd_n;
        ck_d = bus.conv_clk;
    end

    // Sequencer registers; reset leaves the flag inactive
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            state_q <= APH_IDLE;
            cnt_q <= '0;
            ctrl_q <= APH_CTRL_RST;
            result_q <= APH_RESULT_RST;
            done_q <= 1'b0;
            sample_q <= 1'b0;
        end
        else
        begin
            state_q <= state_d;
            cnt_q <= cnt_d;
            ctrl_q <= ctrl_d;
            result_q <= result_d;
            done_q <= done_d;
            sample_q <= sample_d;
        end
    end

    // Read data register
    always_ff @(posedge clk)
    begin
        if (srst)
            data_q <= 8'h00;
        else
            data_q <= data_d;
    end

    // Pin history; strobes reset to their idle high level so no false edge follows
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            wr_q <= 1'b1;
            rd_q <= 1'b1;
            ck_q <= 1'b0;
        end
        else
        begin
            wr_q <= wr_d;
            rd_q <= rd_d;
            ck_q <= ck_d;
        end
    end

    // Pin drivers; release avoids contention with the host
    // Data enable waits a cycle after the strobe fall, so the registered byte is valid
    // The flag enable follows select alone; the flag level itself is held inside
    assign bus.dev_data = data_q;
    assign bus.dev_data_oe = !bus.cs_n && !bus.rd_n && !rd_q; // RULE_02 RULE_05 RULE_12
    assign bus.done_n = !done_q; // RULE_01
    assign bus.done_oe = !bus.cs_n; // RULE_05
    assign ctrl_byte = ctrl_q;
    assign sample_strobe = sample_q;
    assign converting = state_q == APH_CONV;
endmodule

// *** src/aph_host.sv ***
// Microprocessor end: issues control writes and result reads on the byte bus
module aph_host
    import aph_pkg::*;
#(
    parameter int CLK_DIV = APH_CLK_DIV
)
(
    input wire logic clk,
    input wire logic srst,
    input wire logic ext_clock_mode,
    input wire logic static_level,
    input wire logic wr_req,
    input wire logic [7:0] wr_byte,
    input wire logic rd_req,
    input wire logic rd_upper,
    output logic busy,
    output logic rd_valid,
    output logic [7:0] rd_byte,
    output logic done_seen,
    aph_bus_if.host bus
);
    initial
    begin
        if (CLK_DIV < 2 || CLK_DIV > 256 || CLK_DIV % 2 != 0)
            $error("aph_host: CLK_DIV must be even, 2 to 256");
    end

    aph_hstate_e st_q, st_d;
    logic [1:0] ph_q, ph_d;
    logic [7:0] byte_q, byte_d;
    logic up_q, up_d;
    logic rv_q, rv_d;
    logic [7:0] div_q, div_d;
    logic ck_q, ck_d;

    // Strobe sequencer: select leads and trails the two-cycle strobe, then a gap
    always_comb
    begin
        st_d = st_q;
        ph_d = ph_q;
        byte_d = byte_q;
        up_d = up_q;
        rv_d = 1'b0;
        unique case (st_q)
            APH_H_IDLE:
            begin
                ph_d = 2'd0;
                if (wr_req)
                begin
                    st_d = APH_H_WRITE; // RULE_03 RULE_04
                    byte_d = wr_byte;
                end
                else if (rd_req)
                begin
                    st_d = APH_H_READ; // RULE_02
                    up_d = rd_upper;
                end
            end
            APH_H_WRITE, APH_H_READ:
            begin
                ph_d = ph_q + 2'h1;
                // Read byte taken while the strobe is still low
                if (ph_q == 2'h2 && st_q == APH_H_READ)
                begin
                    byte_d = bus.dev_data;
                    rv_d = 1'b1;
                end
                // Select stays low a cycle past the strobe so the device sees its rise
                if (ph_q == 2'h3)
                    st_d = APH_H_GAP;
            end
            APH_H_GAP:
                st_d = APH_H_IDLE;
        endcase
    end

    // Conversion clock pin: divided clock or static level
    always_comb
    begin
        div_d = div_q + 8'h01;
        ck_d = ck_q;
        if (div_q == 8'(CLK_DIV / 2 - 1))
        begin
            div_d = 8'h00;
            ck_d = !ck_q; // RULE_06
        end
    end

    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            st_q <= APH_H_IDLE;
            ph_q <= 2'd0;
            byte_q <= 8'h00;
            up_q <= 1'b0;
            rv_q <= 1'b0;
            div_q <= 8'h00;
            ck_q <= 1'b0;
        end
        else
        begin
            st_q <= st_d;
            ph_q <= ph_d;
            byte_q <= byte_d;
            up_q <= up_d;
            rv_q <= rv_d;
            div_q <= div_d;
            ck_q <= ck_d;
        end
    end

    // Select wraps the strobe; strobe low in phases 1 and 2 only
    assign bus.cs_n = !(st_q == APH_H_WRITE || st_q == APH_H_READ);
    assign bus.wr_n = !(st_q == APH_H_WRITE && (ph_q == 2'h1 || ph_q == 2'h2));
    assign bus.rd_n = !(st_q == APH_H_READ && (ph_q == 2'h1 || ph_q == 2'h2));
    assign bus.upper_nibble_select = up_q;
    assign bus.host_data = byte_q;
    assign bus.host_data_oe = st_q == APH_H_WRITE;
    assign bus.conv_clk = ext_clock_mode ? ck_q : static_level; // RULE_07
    assign busy = st_q != APH_H_IDLE;
    assign rd_valid = rv_q;
    assign rd_byte = byte_q;
    assign done_seen = bus.done_oe && !bus.done_n;
endmodule

// *** verification/aph_port_props.sv ***
// Bus-level checks for the converter host port
module aph_port_props
    import aph_pkg::*;
#(
    parameter int CONV_CYCLES = APH_CONV_CYCLES
)
(
    input wire logic clk,
    input wire logic srst,
    input wire logic cs_n,
    input wire logic wr_n,
    input wire logic rd_n,
    input wire logic upper_nibble_select,
    input wire logic [7:0] dev_data,
    input wire logic dev_data_oe,
    input wire logic done_n,
    input wire logic done_oe
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] since_wr_q;
    logic [7:0] since_wr_d;

    // Cycles since last write release; saturates so long idles stay legal
    always_comb
    begin
        since_wr_d = since_wr_q;
        if (!wr_n)
            since_wr_d = 8'h00;
        else if (since_wr_q != 8'hFF)
            since_wr_d = since_wr_q + 8'h01;
    end

    always_ff @(posedge clk)
        since_wr_q <= srst ? 8'hFF : since_wr_d;

    default clocking @(posedge clk);
    endclocking
    default disable iff (srst);

    // Output drive and flag behaviour
    a_deselect_release: assert property (cs_n |-> !dev_data_oe && !done_oe)
        else $error("outputs driven while deselected");
    a_drive_only_read: assert property (dev_data_oe |-> !cs_n && !rd_n)
        else $error("data driven outside read");
    a_read_drives_bus: assert property (!cs_n && !rd_n && !$past(rd_n) |-> dev_data_oe)
        else $error("read not driving data");
    a_upper_nibble_zero: assert property (dev_data_oe && upper_nibble_select |-> dev_data[7:4] == 4'h0)
        else $error("upper read has nonzero high bits");
    a_flag_read_clear: assert property ($fell(rd_n) && !cs_n |-> ##[1:2] done_n)
        else $error("flag not cleared by read");
    a_flag_write_clear: assert property ($rose(wr_n) |-> ##[1:2] done_n)
        else $error("flag not cleared by write");
    a_conv_min_length: assert property ($fell(done_n) |-> since_wr_q >= CONV_CYCLES)
        else $error("completion too soon after write");
    a_flag_holds_low: assert property (!done_n && cs_n && $past(cs_n) && $past(cs_n, 2) && $past(cs_n, 3) |=> !done_n)
        else $error("flag left low state without access");

    c_done: cover property ($fell(done_n));
    c_upper_read: cover property ($fell(rd_n) && !cs_n && upper_nibble_select);
    c_write_over_done: cover property ($rose(wr_n) && !done_n);
endmodule

// *** verification/tb.sv ***
// Self-checking bench joining host and converter ends of the byte bus
module tb
    import aph_pkg::*;
    ();
    timeunit 1ns;
    timeprecision 1ps;
    localparam int DIV = 4;
    localparam int LAT = APH_ACQ_CYCLES + APH_CONV_CYCLES;
    logic clk = 1'b0;
    logic srst = 1'b1;
    logic ext_mode = 1'b0;
    logic static_level = 1'b1;
    logic wr_req = 1'b0;
    logic [7:0] wr_byte = 8'h00;
    logic rd_req = 1'b0;
    logic rd_upper = 1'b0;
    logic [11:0] sample_in = 12'hA5C;
    logic busy, rd_valid, done_seen, converting;
    logic [7:0] rd_byte, ctrl_byte, got;
    int error_cnt = 0;
    int samples_checked = 0;
    int n;
    aph_bus_if u_bus ();

    aph_device u_aph_device (.clk(clk), .srst(srst), .use_ext_clock(ext_mode),
        .sample_in(sample_in), .ctrl_byte(ctrl_byte), .sample_strobe(),
        .converting(converting), .bus(u_bus.device));
    aph_host #(.CLK_DIV(DIV)) u_aph_host (.clk(clk), .srst(srst), .ext_clock_mode(ext_mode),
        .static_level(static_level), .wr_req(wr_req), .wr_byte(wr_byte), .rd_req(rd_req),
        .rd_upper(rd_upper), .busy(busy), .rd_valid(rd_valid), .rd_byte(rd_byte),
        .done_seen(done_seen), .bus(u_bus.host));
    aph_port_props u_aph_port_props (.clk(clk), .srst(srst), .cs_n(u_bus.cs_n),
        .wr_n(u_bus.wr_n), .rd_n(u_bus.rd_n), .upper_nibble_select(u_bus.upper_nibble_select),
        .dev_data(u_bus.dev_data), .dev_data_oe(u_bus.dev_data_oe), .done_n(u_bus.done_n),
        .done_oe(u_bus.done_oe));

    // Free-running system clock
    always #5 clk = ~clk;

    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic tally_and_finish();
        $display("checks %0d errors %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    // Requests only go in while the host is idle
    task automatic host_write(input logic [7:0] b);
        @(negedge clk);
        wr_req = 1'b1;
        wr_byte = b;
        @(negedge clk);
        wr_req = 1'b0;
        repeat (8) if (busy === 1'b1) @(negedge clk);
    endtask

    task automatic host_read(input logic up, output logic [7:0] b);
        @(negedge clk);
        rd_req = 1'b1;
        rd_upper = up;
        @(negedge clk);
        rd_req = 1'b0;
        repeat (8) if (busy === 1'b1) @(negedge clk);
        b = rd_byte;
    endtask

    // Bounded wait so a missing flag cannot hang the run
    task automatic convert(input logic [7:0] b, input int lo, input int hi);
        host_write(b);
        n = 0;
        while (u_bus.done_n !== 1'b0 && n < 400)
        begin
            @(negedge clk);
            n++;
        end
        check("done latency", 8'(n >= lo && n <= hi), 8'h01);
    endtask

    // Main sequence
    initial
    begin
        repeat (20) @(negedge clk);
        srst = 1'b0;
        check("idle drive", {7'h00, u_bus.dev_data_oe}, 8'h00);
        check("idle flag drive", {7'h00, u_bus.done_oe}, 8'h00);
        check("static clock", {7'h00, u_bus.conv_clk}, 8'h01);
        convert(8'h11, LAT - 2, LAT + 2);
        check("control byte", ctrl_byte, 8'h11);
        host_read(1'b0, got);
        check("low byte", got, 8'h5C);
        check("flag after read", {7'h00, u_bus.done_n}, 8'h01);
        host_read(1'b1, got);
        check("upper byte", got, 8'h0A);
        host_write(8'h31);
        repeat (30) @(negedge clk);
        check("held acquire", {7'h00, u_bus.done_n}, 8'h01);
        check("acquire no convert", {7'h00, converting}, 8'h00);
        convert(8'h11, APH_CONV_CYCLES - 2, APH_CONV_CYCLES + 2);
        sample_in = 12'h3C7;
        host_write(8'h11);
        check("flag after write", {7'h00, u_bus.done_n}, 8'h01);
        repeat (6) @(negedge clk);
        check("mid conversion", {7'h00, converting}, 8'h01);
        convert(8'h11, LAT - 2, LAT + 2);
        host_read(1'b0, got);
        check("low byte 2", got, 8'hC7);
        ext_mode = 1'b1;
        convert(8'h11, (LAT - 1) * DIV, (LAT + 2) * DIV);
        host_read(1'b1, got);
        check("upper byte 2", got, 8'h03);
        tally_and_finish();
    end

    // Watchdog well beyond the expected run length
    initial
    begin
        #100000;
        error_cnt++;
        tally_and_finish();
    end
endmodule
